// ---- acc_pkg.sv ----
// holds constants, register map and state type of the conversion control block
// assumes a 40 MHz core clock and an AHB-Lite master that issues single word transfers
// Operation
// R1 - any write to status_control_one aborts a running conversion and starts anew unless channel all ones; code starts anew only while trigger select is zero
// R2 - done flag at bit 7 sets at every conversion end while compare is off
// R3 - with compare on, done flag sets only when the compare holds
// R4 - done flag clears on write to status_control_one and on reading result_low_byte
// R5 - done flag is read-only; written values at its position are ignored
// R6 - interrupt asserted while done flag is set and interrupt enable bit 6 is one
// R7 - continuous bit 5 clear: one conversion per write or per trigger event
// R8 - continuous bit set: back-to-back conversions after write or trigger event
// R9 - channel field bits 4:0; 0-27 inputs, 29 high ref, 30 low ref, 28 reserved
// R10 - channel code all ones turns converter off, stops continuous with no extra conversion
// R11 - single mode returns converter to low power after each conversion by itself
// R12 - active flag bit 7 of second register set at start, cleared at end or abort
// R13 - trigger select bit 6: zero starts on writes, one on hardware trigger input
// R14 - compare enable bit 5 switches automatic compare of each result on or off
// R15 - bit 4 compare sense: zero means result below value, one means at or above
// R16 - software writes zero to reserved bits 1 and 0 of the second register
// R17 - result registers load at every conversion end unless compare is on and fails
// R18 - in 10-bit mode a high byte read blocks result loads until low byte read
// R19 - in hardware trigger mode a periodic wakeup overflow starts a conversion
// R20 - after reset channel field all ones, other bits and second register zero
package acc_pkg;
  // register byte offsets
  localparam logic [4:0] OFF_SC1 = 5'h00;
  localparam logic [4:0] OFF_SC2 = 5'h04;
  localparam logic [4:0] OFF_RESH = 5'h08;
  localparam logic [4:0] OFF_RESL = 5'h0C;
  localparam logic [4:0] OFF_CMPH = 5'h10;
  localparam logic [4:0] OFF_CMPL = 5'h14;
  localparam logic [4:0] OFF_CFG = 5'h18;
  localparam int ADDR_W = 5;
  // field positions
  localparam int BIT_DONE = 7;
  localparam int BIT_IRQEN = 6;
  localparam int BIT_CONT = 5;
  localparam int BIT_ACTIVE = 7;
  localparam int BIT_TRIG = 6;
  localparam int BIT_CMPEN = 5;
  localparam int BIT_CMPGE = 4;
  localparam int CFG_MODE_LO = 2;
  // channel codes
  localparam logic [4:0] CH_OFF = 5'h1F;
  localparam logic [4:0] CH_RESERVED = 5'h1C;
  localparam logic [4:0] CH_RESET = CH_OFF;
  localparam logic [1:0] MODE_10BIT = 2'h2;
  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int CONV_TIME_NS = 2000;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  // bus answers
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic power;
    logic [4:0] channel;
    logic reservedChannel;
  } accConvCtl_t;

  typedef struct packed {
    logic doneFlag;
    logic irqEnable;
    logic contSelect;
    logic [4:0] channel;
    logic active;
    logic trigSrc;
    logic cmpEnable;
    logic cmpAtOrAbove;
    logic [9:0] cmpVal;
    logic [1:0] mode;
    logic [1:0] resHigh;
    logic [7:0] resLow;
    logic interlock;
    logic contRun;
    logic [CNT_W-1:0] cnt;
    logic [2:0] sync;
    logic trigStable;
    logic dpWrite;
    logic [ADDR_W-1:0] dpAddr;
    logic [31:0] hrdata;
  } accState_t;
endpackage

// ---- acc_conversion_control.sv ----
// conversion control and status with AHB-Lite register slave
// assumes convData from the analog core is stable at conversion end, same clock
`timescale 1ns/100ps
`default_nettype none
module acc_conversion_control #(
  parameter int CONV_CYCLES = acc_pkg::CONV_CYCLES
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic hwTriggerInput,
  input wire logic [9:0] convData,
  output acc_pkg::accConvCtl_t convCtl,
  output logic doneIrq
);
  acc_pkg::accState_t s;
  acc_pkg::accState_t next_s;
  logic take;
  logic wrSc1;
  logic trigEvt;
  logic done;
  logic cmpOk;
  logic startNow;
  logic [9:0] value;
  logic [9:0] cmpRef;

  function automatic logic [31:0] readMux(input acc_pkg::accState_t st, input logic [acc_pkg::ADDR_W-1:0] a);
    logic [31:0] d;
    d = acc_pkg::RD_ZERO;
    unique case (a)
      acc_pkg::OFF_SC1: d[7:0] = {st.doneFlag, st.irqEnable, st.contSelect, st.channel};
      acc_pkg::OFF_SC2: d[7:0] = {st.active, st.trigSrc, st.cmpEnable, st.cmpAtOrAbove, 4'h0};
      acc_pkg::OFF_RESH: d[1:0] = st.resHigh;
      acc_pkg::OFF_RESL: d[7:0] = st.resLow;
      acc_pkg::OFF_CMPH: d[1:0] = st.cmpVal[9:8];
      acc_pkg::OFF_CMPL: d[7:0] = st.cmpVal[7:0];
      acc_pkg::OFF_CFG: d[3:2] = st.mode;
      default: d = acc_pkg::RD_ZERO;
    endcase
    return d;
  endfunction

  function automatic logic isAddr(input logic [acc_pkg::ADDR_W-1:0] a, input logic [acc_pkg::ADDR_W-1:0] b);
    return a == b;
  endfunction

  always_comb begin
    next_s = s;
    startNow = 1'b0;
    done = 1'b0;
    trigEvt = 1'b0;
    // trigger pin: three stages, change counts when last two agree
    next_s.sync = {s.sync[1:0], hwTriggerInput};
    if (s.sync[2] == s.sync[1]) begin
      trigEvt = s.sync[2] & ~s.trigStable; // [R19]
      next_s.trigStable = s.sync[2];
    end
    // data phase write
    wrSc1 = s.dpWrite & isAddr(s.dpAddr, acc_pkg::OFF_SC1);
    if (s.dpWrite) begin
      unique case (s.dpAddr)
        acc_pkg::OFF_SC1: begin
          next_s.irqEnable = hwdata[acc_pkg::BIT_IRQEN];
          next_s.contSelect = hwdata[acc_pkg::BIT_CONT];
          next_s.channel = hwdata[4:0]; // [R9]
          // done bit of hwdata deliberately unused [R5]
        end
        acc_pkg::OFF_SC2: begin
          next_s.trigSrc = hwdata[acc_pkg::BIT_TRIG]; // [R13]
          next_s.cmpEnable = hwdata[acc_pkg::BIT_CMPEN]; // [R14]
          next_s.cmpAtOrAbove = hwdata[acc_pkg::BIT_CMPGE]; // [R15]
        end
        acc_pkg::OFF_CMPH: next_s.cmpVal[9:8] = hwdata[1:0];
        acc_pkg::OFF_CMPL: next_s.cmpVal[7:0] = hwdata[7:0];
        acc_pkg::OFF_CFG: next_s.mode = hwdata[acc_pkg::CFG_MODE_LO +: 2];
        default: next_s.mode = next_s.mode;
      endcase
    end
    // address phase
    take = hsel & hready & htrans[1];
    next_s.dpWrite = take & hwrite;
    next_s.dpAddr = haddr[acc_pkg::ADDR_W-1:0];
    next_s.hrdata = (take & ~hwrite) ? readMux(next_s, haddr[acc_pkg::ADDR_W-1:0]) : acc_pkg::RD_ZERO;
    if (take & ~hwrite) begin
      if (isAddr(haddr[acc_pkg::ADDR_W-1:0], acc_pkg::OFF_RESL)) begin
        next_s.doneFlag = 1'b0; // [R4]
        next_s.interlock = 1'b0; // [R18]
      end
      if (isAddr(haddr[acc_pkg::ADDR_W-1:0], acc_pkg::OFF_RESH) && s.mode == acc_pkg::MODE_10BIT) begin
        next_s.interlock = 1'b1; // [R18]
      end
    end
    // compare of the fresh result
    value = (s.mode == acc_pkg::MODE_10BIT) ? convData : {2'h0, convData[9:2]};
    cmpRef = (s.mode == acc_pkg::MODE_10BIT) ? s.cmpVal : {2'h0, s.cmpVal[7:0]};
    cmpOk = s.cmpAtOrAbove ? (value >= cmpRef) : (value < cmpRef); // [R15]
    if (wrSc1) begin
      next_s.doneFlag = 1'b0; // [R4]
      next_s.active = 1'b0; // [R1] [R12]
      next_s.contRun = 1'b0;
      next_s.cnt = '0;
      if (!s.trigSrc && hwdata[4:0] != acc_pkg::CH_OFF) begin
        startNow = 1'b1; // [R1] [R7] [R8] [R10]
      end
    end else begin
      if (s.active) begin
        if (s.cnt == acc_pkg::CNT_W'(CONV_CYCLES - 1)) begin
          done = 1'b1;
          next_s.active = 1'b0; // [R12] [R11]
          next_s.cnt = '0;
        end else begin
          next_s.cnt = s.cnt + 1'b1;
        end
      end
      if (done) begin
        if (!s.cmpEnable || cmpOk) begin
          next_s.doneFlag = 1'b1; // [R2] [R3]
          if (!next_s.interlock) begin
            next_s.resHigh = (s.mode == acc_pkg::MODE_10BIT) ? convData[9:8] : 2'h0; // [R17]
            next_s.resLow = value[7:0]; // [R17]
          end
        end
        if (s.contSelect && s.channel != acc_pkg::CH_OFF && (!s.trigSrc || s.contRun)) begin
          startNow = 1'b1; // [R8]
        end
      end
      if (trigEvt && s.trigSrc && !s.active && s.channel != acc_pkg::CH_OFF) begin
        startNow = 1'b1; // [R13] [R19] [R7]
        next_s.contRun = s.contSelect; // [R8]
      end
    end
    if (startNow) begin
      next_s.active = 1'b1; // [R12]
      next_s.cnt = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.channel <= acc_pkg::CH_RESET; // [R20]
    end else begin
      s <= next_s;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = acc_pkg::HRESP_OKAY;
  assign hrdata = s.hrdata;
  assign doneIrq = s.doneFlag & s.irqEnable; // [R6]
  assign convCtl.power = s.active; // [R10] [R11]
  assign convCtl.channel = s.channel;
  assign convCtl.reservedChannel = (s.channel == acc_pkg::CH_RESERVED);
endmodule // acc_conversion_control
`default_nettype wire

// ---- acc_conversion_control_asserts.sv ----
// port checks of the conversion control block
// assumes zero wait states and binding to the top module
`timescale 1ns/100ps
`default_nettype none
module acc_conversion_control_asserts (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire acc_pkg::accConvCtl_t convCtl,
  input wire logic doneIrq
);
  logic wrOne;
  logic rdAny;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wrOne <= 1'b0;
      rdAny <= 1'b0;
    end else begin
      wrOne <= hsel && hready && htrans[1] && hwrite && haddr[4:0] == acc_pkg::OFF_SC1;
      rdAny <= hsel && hready && htrans[1] && !hwrite;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_bus_okay: assert property (hreadyout && hresp == acc_pkg::HRESP_OKAY) else $error("bus answer not okay");
  a_rd_zero: assert property (!rdAny |-> hrdata == acc_pkg::RD_ZERO) else $error("read data outside data phase");
  a_chan_write: assert property (wrOne |=> convCtl.channel == $past(hwdata[4:0])) else $error("channel lost");
  a_resv_code: assert property (convCtl.reservedChannel == (convCtl.channel == acc_pkg::CH_RESERVED))
    else $error("reserved code flag wrong");
  a_off_stop: assert property (wrOne && hwdata[4:0] == acc_pkg::CH_OFF |=> !convCtl.power [*2])
    else $error("conversion after off code");
  a_off_idle: assert property (convCtl.channel == acc_pkg::CH_OFF |-> !convCtl.power) else $error("powered while off");
  a_irq_clear: assert property (wrOne |=> !doneIrq) else $error("done kept after write");
  a_irq_rise: assert property ($rose(doneIrq) |-> $past(convCtl.power)) else $error("done without conversion");
  c_done: cover property ($rose(doneIrq));
  c_end: cover property ($fell(convCtl.power));
  c_abort: cover property (wrOne && convCtl.power);
endmodule // acc_conversion_control_asserts
bind acc_conversion_control acc_conversion_control_asserts acc_conversion_control_asserts_inst (.*);
`default_nettype wire

// ---- tb_acc_conversion_control.sv ----
// self-checking bench of the conversion control block
// assumes a short conversion count and a zero wait state slave
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin mismatches++; $display("BAD %s %h %h", n, e, a); end end
module tb_acc_conversion_control;
  logic core_clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hwTriggerInput = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [9:0] convData = '0;
  logic hreadyout, hresp, doneIrq, ge, f;
  logic [7:0] ch;
  acc_pkg::accConvCtl_t convCtl;
  int mismatches = 0, checks_done = 0, i;
  acc_conversion_control #(.CONV_CYCLES(4)) acc_conversion_control_inst (.core_clk(core_clk), .rstn(rstn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .hwTriggerInput(hwTriggerInput), .convData(convData),
    .convCtl(convCtl), .doneIrq(doneIrq));
  initial forever #12.5 core_clk = ~core_clk;
  function automatic logic cmp_true(logic [9:0] d, logic g);
    return g ? d[9:2] >= 8'h80 : d[9:2] < 8'h80;
  endfunction
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task xfer(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {27'h0, a};
    do begin @(posedge core_clk); n++; end while (hreadyout !== 1'b1 && n < 20);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do begin @(posedge core_clk); n++; end while (hreadyout !== 1'b1 && n < 20);
    rd = hrdata;
    if (n >= 20) begin mismatches++; final_report; end
  endtask
  task poll(output logic fl);
    fl = 1'b0;
    for (int k = 0; k < 8 && fl !== 1'b1; k++) begin xfer(0, acc_pkg::OFF_SC1, 0); fl = rd[7]; end
  endtask
  initial begin
    void'($urandom(32'h81e0));
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    xfer(0, acc_pkg::OFF_SC1, 0); `CHK("sc1", 32'h1F, rd)
    xfer(0, acc_pkg::OFF_SC2, 0); `CHK("sc2", 32'h0, rd)
    xfer(0, 5'h1C, 0); `CHK("unmapped", 32'h0, rd)
    for (i = 0; i < 4; i++) begin
      ch = 8'($urandom % 28);
      convData <= 10'($urandom);
      xfer(1, acc_pkg::OFF_SC1, 8'hC0 | ch);
      xfer(0, acc_pkg::OFF_SC2, 0); `CHK("active", 1'b1, rd[7])
      poll(f); `CHK("done", 1'b1, f)
      `CHK("irq", 1'b1, doneIrq)
      xfer(0, acc_pkg::OFF_SC2, 0); `CHK("idle", 1'b0, rd[7])
      xfer(0, acc_pkg::OFF_RESL, 0); `CHK("result", {24'h0, convData[9:2]}, rd)
      xfer(0, acc_pkg::OFF_SC1, 0); `CHK("sc1", {24'h0, 8'h40 | ch}, rd)
    end
    $display("single done");
    xfer(1, acc_pkg::OFF_CMPL, 8'h80);
    for (i = 0; i < 6; i++) begin
      ge = i[0];
      convData <= (i < 2) ? 10'h200 : 10'($urandom);
      xfer(1, acc_pkg::OFF_SC2, {3'h1, ge, 4'h0});
      xfer(1, acc_pkg::OFF_SC1, 8'h01);
      poll(f); `CHK("cmp", cmp_true(convData, ge), f)
      `CHK("irq off", 1'b0, doneIrq)
    end
    $display("compare done");
    xfer(1, acc_pkg::OFF_SC2, 8'h00);
    xfer(1, acc_pkg::OFF_SC1, 8'h23);
    for (i = 0; i < 6; i++) begin
      if (i == 3) xfer(1, acc_pkg::OFF_SC1, acc_pkg::CH_OFF);
      xfer(0, acc_pkg::OFF_SC2, 0); `CHK("cont", 1'(i < 3), rd[7])
    end
    $display("continuous done");
    xfer(1, acc_pkg::OFF_SC2, 8'h40);
    xfer(1, acc_pkg::OFF_SC1, 8'h02);
    poll(f); `CHK("no trig", 1'b0, f)
    hwTriggerInput <= 1'b1;
    poll(f); `CHK("trig", 1'b1, f)
    xfer(0, acc_pkg::OFF_RESL, 0);
    poll(f); `CHK("one conv", 1'b0, f)
    hwTriggerInput <= 1'b0;
    $display("trigger done");
    xfer(1, acc_pkg::OFF_SC2, 8'h00);
    xfer(1, acc_pkg::OFF_CFG, 8'h08);
    convData <= 10'h2A5;
    xfer(1, acc_pkg::OFF_SC1, 8'h04);
    poll(f);
    xfer(0, acc_pkg::OFF_RESH, 0); `CHK("high", 32'h2, rd)
    convData <= 10'h15A;
    xfer(1, acc_pkg::OFF_SC1, 8'h04);
    poll(f);
    xfer(0, acc_pkg::OFF_RESL, 0); `CHK("low held", 32'hA5, rd)
    $display("interlock done");
    xfer(1, acc_pkg::OFF_SC1, 8'h1C);
    @(posedge core_clk);
    `CHK("resv", 1'b1, convCtl.reservedChannel)
    `CHK("resp", acc_pkg::HRESP_OKAY, hresp)
    $display("reserved done");
    final_report;
  end
endmodule // tb_acc_conversion_control
`default_nettype wire
